// >>> rtl/pss_regs.sv
// Slot status, second device/link/slot capability registers behind an APB slave.
// Assumes sensor pins are asynchronous and synchronised here; events from the core are on REF_CLK_I.
//
// Contract
// R1: attention button press latches bit 16, W1C
// R2: power fault latches bit 17, W1C
// R3: latch sensor change bit 18, read-only
// R4: presence change latches bit 19, W1C
// R5: command completion latches bit 20, W1C
// R6: bit 21 mirrors retention latch sensor
// R7: bit 22 reports card presence
// R8: no slot implemented: presence reads one
// R9: link active change sets bit 24, W1C
// R10: LTR supported bit 11 reads one
// R11: OBFF support and FCU LTR loadable
// R12: LTR enable and OBFF enable writable
// R13: de-emphasis select loadable, port dependent reset
// R14: current de-emphasis resets by port type
// R15: zero writes and read-only writes ignored
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "pss_defines.svh"
module pss_regs
  import pss_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Port configuration and sensors
  input  wire logic        DOWNSTREAM_I,
  input  wire logic        SLOT_IMPL_I,
  input  wire logic        ATTN_BUTTON_I,
  input  wire logic        POWER_FAULT_I,
  input  wire logic        LATCH_OPEN_I,
  input  wire logic        CARD_PRESENT_I,
  // Core events
  input  wire logic        CMD_DONE_I,
  input  wire logic        DLL_ACTIVE_I,
  input  wire logic        CUR_DEEMP_I,
  // Steering outputs
  output logic             LTR_EN_O,
  output logic      [1:0]  OBFF_EN_O,
  output pss_link_ctl_t    LINK_CTL_O,
  output logic             IRQ_O
);

  logic [3:0]    sync1_r;
  logic [3:0]    sync2_r;
  logic [3:0]    sens_r;
  logic          dll_r;
  logic          strap_done_r;
  logic [5:0]    evt_r;
  logic [5:0]    evt_nxt;
  logic [5:0]    irq_sts_r;
  logic [5:0]    irq_sts_nxt;
  logic [5:0]    irq_msk_r;
  pss_dev_ctl_t  dev_ctl_r;
  pss_link_ctl_t lnk_ctl_r;
  pss_strap_t    strap_r;
  logic          cur_deemp_r;
  logic [31:0]   prdata_r;
  logic          rd_wait_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire        acc      = PSEL_I & PENABLE_I;
  wire        wr       = acc & PWRITE_I;
  wire        rd       = acc & ~PWRITE_I;
  // A read gets one wait state so that the registered read data stands when pready is high.
  wire        rd_first = rd & ~rd_wait_r;
  wire [7:0]  a        = {PADDR_I[7:2], 2'b00};
  wire        h_slot   = hit(a, `PSS_OFF_SLOT_STS);
  wire        h_dcap   = hit(a, `PSS_OFF_DEV_CAP2);
  wire        h_dctl   = hit(a, `PSS_OFF_DEV_CTL2);
  wire        h_lcap   = hit(a, `PSS_OFF_LNK_CAP2);
  wire        h_lctl   = hit(a, `PSS_OFF_LNK_CTL2);
  wire        h_scap   = hit(a, `PSS_OFF_SLT_CAP2);
  wire        h_sctl   = hit(a, `PSS_OFF_SLT_CTL2);
  wire        h_ists   = hit(a, `PSS_OFF_IRQ_STS);
  wire        h_imsk   = hit(a, `PSS_OFF_IRQ_MSK);
  wire        h_strap  = hit(a, `PSS_OFF_STRAP);
  wire        mapped   = h_slot | h_dcap | h_dctl | h_lcap | h_lctl | h_scap | h_sctl |
                         h_ists | h_imsk | h_strap;
  wire        btn_s    = sync2_r[0];
  wire        pf_s     = sync2_r[1];
  wire        latch_s  = sync2_r[2];
  wire        pres_s   = sync2_r[3];
  wire        btn_rise = btn_s & ~sens_r[0];
  wire        pf_rise  = pf_s & ~sens_r[1];
  wire        latch_ch = latch_s ^ sens_r[2];
  wire        pres_ch  = pres_s ^ sens_r[3];
  wire        dll_ch   = DLL_ACTIVE_I ^ dll_r;
  // Event order: attention, fault, latch change, presence change, command done, link change.
  wire [5:0]  evt_set  = {dll_ch, CMD_DONE_I, pres_ch, latch_ch, pf_rise, btn_rise};
  wire        w1c_slot = wr & h_slot;
  wire [5:0]  w1c_mask = w1c_slot ? {PWDATA_I[`PSS_BIT_DLL_CHG], PWDATA_I[`PSS_BIT_CMD_DONE],
                                     PWDATA_I[`PSS_BIT_PRES_CHG], 1'b0,
                                     PWDATA_I[`PSS_BIT_PFAULT], PWDATA_I[`PSS_BIT_ATTN]}
                                  : 6'h00; // [R15]
  wire        pres_rd  = SLOT_IMPL_I ? pres_s : 1'b1; // [R7] [R8]

  // The latch change flag is read-only, so it clears on its own when the sensor settles.
  assign evt_nxt = {evt_set[5:3] | (evt_r[5:3] & ~w1c_mask[5:3]), // [R4] [R5] [R9]
                    evt_set[2], // [R3]
                    evt_set[1:0] | (evt_r[1:0] & ~w1c_mask[1:0])}; // [R1] [R2]
  assign irq_sts_nxt = evt_set | ((rd_first & h_ists) ? 6'h00 : irq_sts_r);

  wire [31:0] slot_rd  = {7'h00, evt_r[5], 1'b0, pres_rd, latch_s, // [R6]
                          evt_r[4:0], 16'h0000};
  wire [31:0] dcap_rd  = (32'h1 << `PSS_BIT_LTR_SUP) | // [R10]
                         ({31'h0, strap_r.fcu_ltr} << `PSS_BIT_FCU_LTR) |
                         ({30'h0, strap_r.obff_sup} << `PSS_POS_OBFF_SUP); // [R11]
  wire [31:0] dctl_rd  = ({31'h0, dev_ctl_r.ltr_en} << `PSS_BIT_LTR_EN) |
                         ({30'h0, dev_ctl_r.obff_en} << `PSS_POS_OBFF_EN);
  wire [31:0] lctl_rd  = {15'h0000, cur_deemp_r, 3'h0, lnk_ctl_r.comp_deemp,
                          lnk_ctl_r.comp_sos, lnk_ctl_r.mod_comp, lnk_ctl_r.tx_margin,
                          strap_r.sel_deemp, lnk_ctl_r.hardware_speed_change_disable,
                          lnk_ctl_r.enter_comp, lnk_ctl_r.tgt_speed};
  wire [31:0] strap_rd = {28'h0000000, strap_r.fcu_ltr, strap_r.obff_sup, strap_r.sel_deemp};
  wire [31:0] rd_mux   = h_slot  ? slot_rd :
                         h_dcap  ? dcap_rd :
                         h_dctl  ? dctl_rd :
                         h_lctl  ? lctl_rd :
                         h_ists  ? {26'h0, irq_sts_r} :
                         h_imsk  ? {26'h0, irq_msk_r} :
                         h_strap ? strap_rd : 32'h00000000;

  assign PREADY_O   = ~rd | rd_wait_r;
  assign PSLVERR_O  = acc & ~mapped;
  assign PRDATA_O   = prdata_r;
  assign LTR_EN_O   = dev_ctl_r.ltr_en;
  assign OBFF_EN_O  = dev_ctl_r.obff_en;
  assign LINK_CTL_O = lnk_ctl_r;
  assign IRQ_O      = |(irq_sts_r & irq_msk_r);

  always_ff @(posedge REF_CLK_I) begin
    sync1_r <= {CARD_PRESENT_I, LATCH_OPEN_I, POWER_FAULT_I, ATTN_BUTTON_I};
    sync2_r <= sync1_r;
    if (RST_I) begin
      // Edge detectors follow the pins during reset so that no false change follows release.
      sens_r       <= sync2_r;
      dll_r        <= DLL_ACTIVE_I;
      evt_r        <= 6'h00;
      irq_sts_r    <= 6'h00;
      prdata_r     <= 32'h00000000;
      rd_wait_r    <= 1'b0;
      strap_done_r <= 1'b0;
    end else begin
      sens_r       <= sync2_r;
      dll_r        <= DLL_ACTIVE_I;
      evt_r        <= evt_nxt;
      irq_sts_r    <= irq_sts_nxt;
      prdata_r     <= rd_first ? rd_mux : prdata_r;
      rd_wait_r    <= rd_first;
      strap_done_r <= 1'b1;
    end
  end

  // Port-type dependent defaults are caught in the first cycle after reset release.
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      strap_r     <= '0;
      cur_deemp_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_r.sel_deemp <= DOWNSTREAM_I; // [R13]
      cur_deemp_r       <= DOWNSTREAM_I; // [R14]
    end else begin
      if (wr && h_strap) begin
        strap_r.sel_deemp <= PWDATA_I[0]; // [R13]
        strap_r.obff_sup  <= PWDATA_I[2:1]; // [R11]
        strap_r.fcu_ltr   <= PWDATA_I[3]; // [R11]
      end
      cur_deemp_r <= CUR_DEEMP_I;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      dev_ctl_r           <= '0;
      lnk_ctl_r           <= '0;
      lnk_ctl_r.tgt_speed <= `PSS_RST_TGT_SPEED;
      irq_msk_r           <= 6'h00;
    end else begin
      if (wr && h_dctl) begin
        dev_ctl_r.ltr_en  <= PWDATA_I[`PSS_BIT_LTR_EN]; // [R12]
        dev_ctl_r.obff_en <= PWDATA_I[`PSS_POS_OBFF_EN +: 2]; // [R12]
      end
      if (wr && h_lctl) begin
        lnk_ctl_r.tgt_speed  <= PWDATA_I[`PSS_POS_TGT_SPEED +: 4];
        lnk_ctl_r.enter_comp <= PWDATA_I[`PSS_BIT_ENTER_COMP];
        lnk_ctl_r.hardware_speed_change_disable <= PWDATA_I[`PSS_BIT_HW_SPD_DIS];
        lnk_ctl_r.tx_margin  <= PWDATA_I[`PSS_POS_TX_MARGIN +: 3];
        lnk_ctl_r.mod_comp   <= PWDATA_I[`PSS_BIT_MOD_COMP];
        lnk_ctl_r.comp_sos   <= PWDATA_I[`PSS_BIT_COMP_SOS];
        lnk_ctl_r.comp_deemp <= PWDATA_I[`PSS_BIT_COMP_DEEMP];
      end
      if (wr && h_imsk) begin
        irq_msk_r <= PWDATA_I[5:0];
      end
    end
  end

endmodule // pss_regs

// >>> rtl/pss_defines.svh
// Register offsets, field positions and reset values of the slot status and second capability slice.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
`define PSS_OFF_SLOT_STS     8'hD8
`define PSS_OFF_DEV_CAP2     8'hE4
`define PSS_OFF_DEV_CTL2     8'hE8
`define PSS_OFF_LNK_CAP2     8'hEC
`define PSS_OFF_LNK_CTL2     8'hF0
`define PSS_OFF_SLT_CAP2     8'hF4
`define PSS_OFF_SLT_CTL2     8'hF8
`define PSS_OFF_IRQ_STS      8'hFC
`define PSS_OFF_IRQ_MSK      8'hE0
`define PSS_OFF_STRAP        8'hDC
`define PSS_BIT_ATTN         16
`define PSS_BIT_PFAULT       17
`define PSS_BIT_LATCH_CHG    18
`define PSS_BIT_PRES_CHG     19
`define PSS_BIT_CMD_DONE     20
`define PSS_BIT_LATCH_ST     21
`define PSS_BIT_PRES_ST      22
`define PSS_BIT_DLL_CHG      24
`define PSS_BIT_LTR_SUP      11
`define PSS_BIT_FCU_LTR      12
`define PSS_POS_OBFF_SUP     18
`define PSS_BIT_LTR_EN       10
`define PSS_POS_OBFF_EN      13
`define PSS_POS_TGT_SPEED    0
`define PSS_BIT_ENTER_COMP   4
`define PSS_BIT_HW_SPD_DIS   5
`define PSS_BIT_SEL_DEEMP    6
`define PSS_POS_TX_MARGIN    7
`define PSS_BIT_MOD_COMP     10
`define PSS_BIT_COMP_SOS     11
`define PSS_BIT_COMP_DEEMP   12
`define PSS_BIT_CUR_DEEMP    16
`define PSS_RST_TGT_SPEED    4'h2
`define PSS_RST_OBFF_SUP     2'h0
`define PSS_NUM_EVT          6
`endif

// >>> rtl/pss_pkg.sv
// Types shared by the slot status and second capability register slice.
// Assumes the defines header is on the include path.
`include "pss_defines.svh"
package pss_pkg;
  typedef struct packed {
    logic [2:0] tx_margin;
    logic       comp_deemp;
    logic       comp_sos;
    logic       mod_comp;
    logic       hardware_speed_change_disable;
    logic       enter_comp;
    logic [3:0] tgt_speed;
  } pss_link_ctl_t;
  typedef struct packed {
    logic       ltr_en;
    logic [1:0] obff_en;
  } pss_dev_ctl_t;
  typedef struct packed {
    logic       fcu_ltr;
    logic [1:0] obff_sup;
    logic       sel_deemp;
  } pss_strap_t;
endpackage

// >>> sim/pss_regs_chk.sv
// Port assertions of pss_regs.
// Assumes the bind below attaches it to pss_regs.
`timescale 1ns/10ps
module pss_regs_chk (
  input wire logic        REF_CLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I, PRDATA_O,
  input wire logic        PSLVERR_O, SLOT_IMPL_I, LTR_EN_O, IRQ_O,
  input wire logic [1:0]  OBFF_EN_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  wire       acc = PSEL_I & PENABLE_I;
  wire [5:0] wa  = PADDR_I[7:2];
  wire       rd  = acc & !PWRITE_I;
  wire       w8  = acc & PWRITE_I & (wa == 6'h3A);
  property p_err; PSLVERR_O |-> acc; endproperty
  a_err: assert property (p_err) else $error("stray slverr");
  property p_ltr; w8 |=> LTR_EN_O == $past(PWDATA_I[10]); endproperty
  a_ltr: assert property (p_ltr) else $error("ltr enable");
  property p_obff; w8 |=> OBFF_EN_O == $past(PWDATA_I[14:13]); endproperty
  a_obff: assert property (p_obff) else $error("obff enable");
  property p_hold; !w8 |=> $stable({LTR_EN_O, OBFF_EN_O}); endproperty
  a_hold: assert property (p_hold) else $error("control moved");
  property p_cap; rd && wa == 6'h39 |=> PRDATA_O[31:20] == 0 && PRDATA_O[11:0] == 12'h800;
  endproperty
  a_cap: assert property (p_cap) else $error("capability");
  property p_pres; !SLOT_IMPL_I [*5] ##0 (rd && wa == 6'h36) |=> PRDATA_O[22]; endproperty
  a_pres: assert property (p_pres) else $error("presence");
  property p_rsv; rd && wa == 6'h36 |=> PRDATA_O[15:0] == 0 && PRDATA_O[31:25] == 0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("slot reserved");
  property p_ctl; rd && wa == 6'h3A |=> (PRDATA_O & ~32'h6400) == 0; endproperty
  a_ctl: assert property (p_ctl) else $error("control reserved");
  property p_lnk; rd && wa == 6'h3C |=> PRDATA_O[31:17] == 0 && PRDATA_O[15:13] == 0;
  endproperty
  a_lnk: assert property (p_lnk) else $error("link reserved");
  c_irq: cover property ($rose(IRQ_O));
  c_err: cover property (PSLVERR_O);
  c_wr: cover property (w8);
endmodule // pss_regs_chk
bind pss_regs pss_regs_chk i_pss_regs_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O),
  .SLOT_IMPL_I(SLOT_IMPL_I), .LTR_EN_O(LTR_EN_O), .OBFF_EN_O(OBFF_EN_O));

// >>> sim/pss_regs_test.sv
// Self-checking bench of pss_regs over APB.
// Assumes the checker file is compiled with it.
`timescale 1ns/10ps
module pss_regs_test;
  import pss_pkg::*;
  logic clk = 0, rst = 1, sel = 0, en = 0, we = 0, dn = 1, si = 1, e;
  logic at = 0, pf = 0, lo = 0, cp = 0, cd = 0, dl = 0, de = 1;
  logic [7:0]  ad = 0;
  logic [31:0] wd = 0, q;
  logic [5:0]  m, k, c;
  wire [31:0]  rdat;
  wire         rdy, err, ltr, irq;
  wire [1:0]   obff;
  pss_link_ctl_t lctl;
  int failures = 0, compares = 0;
  pss_regs i_pss_regs (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(sel), .PENABLE_I(en),
    .PWRITE_I(we), .PADDR_I(ad), .PWDATA_I(wd), .PRDATA_O(rdat), .PREADY_O(rdy),
    .PSLVERR_O(err), .DOWNSTREAM_I(dn), .SLOT_IMPL_I(si), .ATTN_BUTTON_I(at),
    .POWER_FAULT_I(pf), .LATCH_OPEN_I(lo), .CARD_PRESENT_I(cp), .CMD_DONE_I(cd),
    .DLL_ACTIVE_I(dl), .CUR_DEEMP_I(de), .LTR_EN_O(ltr), .OBFF_EN_O(obff),
    .LINK_CTL_O(lctl), .IRQ_O(irq));
  initial forever #4 clk = ~clk;
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    compares++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic xf(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    sel <= 1;
    we <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    en <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    e = err;
    q = rdat;
    sel <= 0;
    en <= 0;
    if (n >= 20) begin
      failures++;
      report_and_stop;
    end
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] x);
    xf(0, a, 0);
    chk($sformatf("read %h", a), x, q);
  endtask
  task automatic do_reset;
    rst <= 1;
    repeat (6) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [31:0] fs(logic [5:0] v);
    return {7'h0, v[5], 1'b0, cp | ~si, lo, v[4], v[3], 1'b0, v[1], v[0], 16'h0};
  endfunction
  initial begin
    void'($urandom(32'h1CD9620C));
    do_reset;
    rc(8'hD8, 0);
    rc(8'hE4, 32'h800);
    rc(8'hF0, 32'h10042);
    rc(8'hEC, 0);
    rc(8'hF8, 0);
    rc(8'h00, 0);
    chk("slverr", 1, e);
    xf(1, 8'hE8, '1);
    rc(8'hE8, 32'h6400);
    chk("ltr_obff", 3'h7, {ltr, obff});
    xf(1, 8'hF0, '1);
    rc(8'hF0, 32'h11FFF);
    chk("link_ctl", 32'hFFF, lctl);
    xf(1, 8'hF0, 0);
    xf(1, 8'hDC, 32'hE);
    rc(8'hE4, 32'hC1800);
    rc(8'hF0, 32'h10000);
    for (int i = 0; i < 4; i++) begin
      m = i < 2 ? 6'h3F : 6'($urandom);
      k = i == 0 ? 6'h0 : (i == 1 ? 6'h3F : 6'($urandom));
      c = 6'($urandom);
      xf(1, 8'hE0, k);
      @(posedge clk);
      {dl, cd, cp, lo, pf, at} <= {dl ^ m[5], m[4], cp ^ m[3], lo ^ m[2], m[1:0]};
      @(posedge clk);
      cd <= 0;
      repeat (6) @(posedge clk);
      #1 chk("irq", |(m & k), irq);
      rc(8'hD8, fs(m));
      xf(1, 8'hD8, 0);
      rc(8'hD8, fs(m));
      xf(1, 8'hD8, {7'h7F, c[5], 3'h7, c[4], c[3], 1'b1, c[1], c[0], 16'hFFFF});
      rc(8'hD8, fs(m & ~c));
      rc(8'hFC, m);
      chk("irq clear", 0, irq);
      at <= 0;
      pf <= 0;
      xf(1, 8'hD8, '1);
    end
    si <= 0;
    de <= 0;
    repeat (8) @(posedge clk);
    rc(8'hD8, fs(0));
    rc(8'hF0, 0);
    dn <= 0;
    si <= 1;
    do_reset;
    rc(8'hF0, 32'h2);
    rc(8'hD8, fs(0));
    rc(8'hE4, 32'h800);
    report_and_stop;
  end
endmodule // pss_regs_test
